/* File: pkg/seq_pkg.sv */
// shared constants, commands, states and carrier structs of the interrupt sequencer
package seq_pkg;

   // register word offsets on the bus
   localparam logic [7:0] OFF_CMD    = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_CC     = 8'h08;
   localparam logic [7:0] OFF_A      = 8'h0C;
   localparam logic [7:0] OFF_B      = 8'h10;
   localparam logic [7:0] OFF_DP     = 8'h14;
   localparam logic [7:0] OFF_X      = 8'h18;
   localparam logic [7:0] OFF_Y      = 8'h1C;
   localparam logic [7:0] OFF_U      = 8'h20;
   localparam logic [7:0] OFF_S      = 8'h24;
   localparam logic [7:0] OFF_PC     = 8'h28;

   // condition code bit positions
   localparam int CC_E = 7;
   localparam int CC_F = 6;
   localparam int CC_I = 4;

   // restart values, undefined code bits taken as zero
   localparam logic [7:0] CC_RESET = 8'h50;
   localparam logic [7:0] DP_RESET = 8'h00;

   // vector addresses (high byte at the given address)
   localparam logic [15:0] VEC_SOFT_THREE = 16'hFFF2;
   localparam logic [15:0] VEC_SOFT_TWO   = 16'hFFF4;
   localparam logic [15:0] VEC_FAST       = 16'hFFF6;
   localparam logic [15:0] VEC_NORMAL     = 16'hFFF8;
   localparam logic [15:0] VEC_NONMASK    = 16'hFFFC;
   localparam logic [15:0] VEC_RESTART    = 16'hFFFE;

   // cycles a level request must stand before it counts
   localparam logic [1:0] HOLD_CYCLES = 2'h3;

   // byte steps of the stack frame
   localparam logic [3:0] STEP_PCH     = 4'h1;
   localparam logic [3:0] STEP_PULL_PC = 4'hA;
   localparam logic [3:0] STEP_LAST    = 4'hB;

   typedef enum logic [2:0] {
      CMD_NONE       = 3'h0,
      CMD_SOFT_TWO   = 3'h1,
      CMD_SOFT_THREE = 3'h2,
      CMD_SYNC       = 3'h3,
      CMD_RETURN     = 3'h4,
      CMD_CLEAR_WAIT = 3'h5
   } cmd_t;

   typedef enum logic [8:0] {
      ST_IDLE  = 9'b000000001,
      ST_PUSH  = 9'b000000010,
      ST_VEC0  = 9'b000000100,
      ST_VEC1  = 9'b000001000,
      ST_VEC2  = 9'b000010000,
      ST_PULL  = 9'b000100000,
      ST_SYNC  = 9'b001000000,
      ST_WAITI = 9'b010000000,
      ST_SPARE = 9'b100000000
   } seq_state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
      logic        addr_oe;
      logic        data_oe;
   } mem_out_t;

   typedef struct packed {
      logic [7:0]  condition_code_reg;
      logic [7:0]  accumulator_high;
      logic [7:0]  accumulator_low;
      logic [7:0]  direct_page_reg;
      logic [15:0] index_reg_x;
      logic [15:0] index_reg_y;
      logic [15:0] user_stack_ptr;
      logic [15:0] hardware_stack_ptr;
      logic [15:0] program_counter;
   } core_regs_t;

endpackage

/* File: rtl/req_hold.sv */
// qualifies an active-low level request that must stand several cycles
`timescale 1ns/1ps
module req_hold (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic ce,
   input  wire logic req_n,
   output logic      held
);
   typedef struct packed {
      logic [1:0] count;
   } hold_t;

   hold_t r;
   hold_t next_r;

   // saturating count of low cycles, cleared when the line goes high
   always_comb begin
      next_r = r;
      if (req_n) begin
         next_r.count = 2'h0;
      end else if (r.count != seq_pkg::HOLD_CYCLES) begin
         next_r.count = r.count + 2'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end

   // short glitches never qualify
   assign held = !req_n && (r.count == seq_pkg::HOLD_CYCLES);
endmodule

/* File: rtl/nmi_edge.sv */
// falling-edge latch of the non-maskable request, armed by a stack pointer load
`timescale 1ns/1ps
module nmi_edge (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic ce,
   input  wire logic req_n,
   input  wire logic stack_load,
   input  wire logic take,
   output logic      latched,
   output logic      go,
   output logic      armed
);
   typedef struct packed {
      logic prev;
      logic latched;
      logic armed;
   } edge_t;

   edge_t r;
   edge_t next_r;
   logic  fall;

   // a new edge in the cycle it is taken is kept, set beats clear
   always_comb begin
      next_r = r;
      fall = r.prev && !req_n;
      next_r.prev = req_n;
      if (fall) begin
         next_r.latched = 1'b1;                    // [RULE14]
      end else if (take) begin
         next_r.latched = 1'b0;
      end
      if (stack_load) begin
         next_r.armed = 1'b1;                      // [RULE15]
      end
   end

   // prev starts high so a line held low out of reset gives an edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= 3'b100;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign latched = r.latched;
   assign armed   = r.armed;
   assign go      = r.latched && r.armed;          // [RULE15]
endmodule

/* File: rtl/cpu_interrupt_sequencer.sv */
// exception and interrupt sequencer with its core registers behind an ahb-lite slave
`timescale 1ns/1ps
// Operation
// [RULE1] full-state entry sets E, then pushes PC..CC with pre-decremented stack pointer
// [RULE2] soft trap two saves everything, then vectors through FFF4/FFF5
// [RULE3] soft trap three saves everything, then vectors through FFF2/FFF3
// [RULE4] both soft traps leave fast and normal mask bits untouched
// [RULE5] sync command stops all instruction work until an interrupt line acts
// [RULE6] sync exit: enabled and held three cycles services, otherwise simply resumes
// [RULE7] while synchronising, address and data bus drivers are released
// [RULE8] any interrupt line, masked or not, ends the synchronising wait
// [RULE9] fast entry pushes PC, clears E, pushes CC, sets both masks, vectors FFF6
// [RULE10] fast request during clear-and-wait enters with the whole state already stacked
// [RULE11] normal entry saves everything with E set, sets normal mask, vectors FFF8
// [RULE12] normal entry leaves fast mask clear so fast may nest; not the reverse
// [RULE13] non-maskable edge pushes all but the stack pointer and vectors through
// [RULE14] every separate falling edge yields its own non-maskable service
// [RULE15] after restart non-maskable service waits for the first stack pointer load
// [RULE16] restart sets both masks and clears the direct page register
// [RULE17] restart fetches the start address from its vector, stacking nothing
// [RULE18] return pulls CC first, then all registers if E set, else only PC
// [RULE19] non-maskable sets both masks, vector FFFC; restart vector at FFFE
// [RULE20] pending hardware requests served non-maskable, then fast, then normal
module cpu_interrupt_sequencer (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              ce,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire logic              nonmask_request_n,
   input  wire logic              fast_request_input_n,
   input  wire logic              normal_request_n,
   input  wire logic [7:0]        mem_rdata,
   output seq_pkg::mem_out_t      mem
);
   typedef struct packed {
      seq_pkg::seq_state_t state;
      seq_pkg::core_regs_t regs;
      logic [3:0]          step;
      logic                full;
      logic                wait_after;
      logic                set_f;
      logic                set_i;
      logic [15:0]         vec;
      logic                sync_seen;
      seq_pkg::cmd_t       cmd;
      seq_pkg::mem_out_t   mem;
      logic                a_valid;
      logic                a_write;
      logic [7:0]          a_addr;
      logic [31:0]         hrdata;
   } seq_t;

   // out of reset the sequencer fetches the restart vector with masks set
   localparam seq_t SEQ_RESET = '{
      state:      seq_pkg::ST_VEC0,
      regs:       '{condition_code_reg: seq_pkg::CC_RESET, direct_page_reg: seq_pkg::DP_RESET, default: '0},
      step:       4'h0,
      full:       1'b0,
      wait_after: 1'b0,
      set_f:      1'b1,
      set_i:      1'b1,
      vec:        seq_pkg::VEC_RESTART,
      sync_seen:  1'b0,
      cmd:        seq_pkg::CMD_NONE,
      mem:        '{addr_oe: 1'b1, default: '0},
      a_valid:    1'b0,
      a_write:    1'b0,
      a_addr:     8'h00,
      hrdata:     32'h00000000
   };

   seq_t r;
   seq_t next_r;
   logic nmi_take;
   logic stack_load;
   logic nmi_latched;
   logic nmi_go;
   logic nmi_armed;
   logic fast_held;
   logic normal_held;
   logic fast_ok;
   logic normal_ok;
   logic any_line;
   logic any_enabled;
   logic addr_phase;

   req_hold u_fast_hold (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .req_n   (fast_request_input_n),
      .held    (fast_held)
   );

   req_hold u_normal_hold (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .req_n   (normal_request_n),
      .held    (normal_held)
   );

   nmi_edge u_nmi_edge (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .req_n   (nonmask_request_n),
      .stack_load (stack_load),
      .take    (nmi_take),
      .latched (nmi_latched),
      .go      (nmi_go),
      .armed   (nmi_armed)
   );

   // byte pushed at each step of the frame, program counter low first
   function automatic logic [7:0] push_byte(input seq_pkg::core_regs_t g, input logic [3:0] idx);
      logic [7:0] b;
      b = g.condition_code_reg;
      unique case (idx)
         4'h0: b = g.program_counter[7:0];
         4'h1: b = g.program_counter[15:8];
         4'h2: b = g.user_stack_ptr[7:0];
         4'h3: b = g.user_stack_ptr[15:8];
         4'h4: b = g.index_reg_y[7:0];
         4'h5: b = g.index_reg_y[15:8];
         4'h6: b = g.index_reg_x[7:0];
         4'h7: b = g.index_reg_x[15:8];
         4'h8: b = g.direct_page_reg;
         4'h9: b = g.accumulator_low;
         4'hA: b = g.accumulator_high;
         default: b = g.condition_code_reg;
      endcase
      return b;
   endfunction

   // request qualification against the live mask bits
   assign fast_ok     = fast_held && !r.regs.condition_code_reg[seq_pkg::CC_F];
   assign normal_ok   = normal_held && !r.regs.condition_code_reg[seq_pkg::CC_I];
   assign any_line    = nmi_latched || !fast_request_input_n || !normal_request_n;
   assign any_enabled = nmi_go || (!fast_request_input_n && !r.regs.condition_code_reg[seq_pkg::CC_F])
                        || (!normal_request_n && !r.regs.condition_code_reg[seq_pkg::CC_I]);
   assign addr_phase  = hsel && hready && htrans[1];

   always_comb begin
      next_r = r;
      nmi_take = 1'b0;
      stack_load = 1'b0;
      next_r.mem.we = 1'b0;
      next_r.mem.re = 1'b0;

      // bus address phase: capture control, stage read data for the data phase
      next_r.a_valid = addr_phase;
      next_r.a_write = hwrite;
      next_r.a_addr = haddr[7:0];
      if (addr_phase && !hwrite) begin
         unique case (haddr[7:0])
            seq_pkg::OFF_CMD:    next_r.hrdata = {29'h0, r.cmd};
            seq_pkg::OFF_STATUS: next_r.hrdata = {16'h0, 1'b0, nmi_armed, nmi_latched, fast_held, normal_held, 2'b00,
                                                  r.state};
            seq_pkg::OFF_CC:     next_r.hrdata = {24'h0, r.regs.condition_code_reg};
            seq_pkg::OFF_A:      next_r.hrdata = {24'h0, r.regs.accumulator_high};
            seq_pkg::OFF_B:      next_r.hrdata = {24'h0, r.regs.accumulator_low};
            seq_pkg::OFF_DP:     next_r.hrdata = {24'h0, r.regs.direct_page_reg};
            seq_pkg::OFF_X:      next_r.hrdata = {16'h0, r.regs.index_reg_x};
            seq_pkg::OFF_Y:      next_r.hrdata = {16'h0, r.regs.index_reg_y};
            seq_pkg::OFF_U:      next_r.hrdata = {16'h0, r.regs.user_stack_ptr};
            seq_pkg::OFF_S:      next_r.hrdata = {16'h0, r.regs.hardware_stack_ptr};
            seq_pkg::OFF_PC:     next_r.hrdata = {16'h0, r.regs.program_counter};
            default:             next_r.hrdata = 32'h00000000;
         endcase
      end

      // bus data phase writes; core registers only change while idle
      if (r.a_valid && r.a_write) begin
         if (r.a_addr == seq_pkg::OFF_CMD) begin
            if (r.cmd == seq_pkg::CMD_NONE && hwdata[2:0] <= 3'h5) begin
               next_r.cmd = seq_pkg::cmd_t'(hwdata[2:0]);
            end
         end else if (r.state == seq_pkg::ST_IDLE) begin
            unique case (r.a_addr)
               seq_pkg::OFF_CC: next_r.regs.condition_code_reg = hwdata[7:0];
               seq_pkg::OFF_A:  next_r.regs.accumulator_high = hwdata[7:0];
               seq_pkg::OFF_B:  next_r.regs.accumulator_low = hwdata[7:0];
               seq_pkg::OFF_DP: next_r.regs.direct_page_reg = hwdata[7:0];
               seq_pkg::OFF_X:  next_r.regs.index_reg_x = hwdata[15:0];
               seq_pkg::OFF_Y:  next_r.regs.index_reg_y = hwdata[15:0];
               seq_pkg::OFF_U:  next_r.regs.user_stack_ptr = hwdata[15:0];
               seq_pkg::OFF_PC: next_r.regs.program_counter = hwdata[15:0];
               seq_pkg::OFF_S: begin
                  next_r.regs.hardware_stack_ptr = hwdata[15:0];
                  stack_load = 1'b1;                                   // [RULE15]
               end
               default: ;
            endcase
         end
      end

      unique case (r.state)
         // instruction boundary: hardware first, in fixed priority, then software
         seq_pkg::ST_IDLE: begin
            next_r.step = 4'h0;
            next_r.wait_after = 1'b0;
            next_r.full = 1'b1;
            if (nmi_go) begin                                         // [RULE20]
               nmi_take = 1'b1;
               next_r.state = seq_pkg::ST_PUSH;                       // [RULE13]
               next_r.regs.condition_code_reg[seq_pkg::CC_E] = 1'b1;
               next_r.vec = seq_pkg::VEC_NONMASK;                     // [RULE19]
               next_r.set_f = 1'b1;
               next_r.set_i = 1'b1;
            end else if (fast_ok) begin                               // [RULE20]
               next_r.state = seq_pkg::ST_PUSH;                       // [RULE9]
               next_r.full = 1'b0;
               next_r.vec = seq_pkg::VEC_FAST;
               next_r.set_f = 1'b1;
               next_r.set_i = 1'b1;
            end else if (normal_ok) begin                             // [RULE20]
               next_r.state = seq_pkg::ST_PUSH;                       // [RULE11]
               next_r.regs.condition_code_reg[seq_pkg::CC_E] = 1'b1;
               next_r.vec = seq_pkg::VEC_NORMAL;
               next_r.set_f = 1'b0;                                   // [RULE12]
               next_r.set_i = 1'b1;
            end else if (r.cmd != seq_pkg::CMD_NONE) begin
               next_r.cmd = seq_pkg::CMD_NONE;
               next_r.set_f = 1'b0;                                   // [RULE4]
               next_r.set_i = 1'b0;
               unique case (r.cmd)
                  seq_pkg::CMD_SOFT_TWO: begin
                     next_r.state = seq_pkg::ST_PUSH;                 // [RULE1]
                     next_r.regs.condition_code_reg[seq_pkg::CC_E] = 1'b1;
                     next_r.vec = seq_pkg::VEC_SOFT_TWO;              // [RULE2]
                  end
                  seq_pkg::CMD_SOFT_THREE: begin
                     next_r.state = seq_pkg::ST_PUSH;                 // [RULE1]
                     next_r.regs.condition_code_reg[seq_pkg::CC_E] = 1'b1;
                     next_r.vec = seq_pkg::VEC_SOFT_THREE;            // [RULE3]
                  end
                  seq_pkg::CMD_CLEAR_WAIT: begin
                     next_r.state = seq_pkg::ST_PUSH;
                     next_r.regs.condition_code_reg[seq_pkg::CC_E] = 1'b1;
                     next_r.wait_after = 1'b1;                        // [RULE10]
                  end
                  seq_pkg::CMD_SYNC: begin
                     next_r.state = seq_pkg::ST_SYNC;                 // [RULE5]
                     next_r.sync_seen = 1'b0;
                  end
                  seq_pkg::CMD_RETURN: begin
                     next_r.state = seq_pkg::ST_PULL;                 // [RULE18]
                     next_r.mem.addr = r.regs.hardware_stack_ptr;
                     next_r.mem.re = 1'b1;
                  end
                  default: ;
               endcase
            end
         end
         // one byte per cycle, stack pointer decremented before each write
         seq_pkg::ST_PUSH: begin
            next_r.regs.hardware_stack_ptr = r.regs.hardware_stack_ptr - 16'h0001;     // [RULE1]
            next_r.mem.addr = next_r.regs.hardware_stack_ptr;
            next_r.mem.wdata = push_byte(r.regs, r.step);
            next_r.mem.we = 1'b1;
            if (!r.full && r.step == seq_pkg::STEP_LAST) begin
               next_r.regs.condition_code_reg[seq_pkg::CC_E] = 1'b0;                 // [RULE9]
               next_r.mem.wdata = next_r.regs.condition_code_reg;
            end
            if (r.step == seq_pkg::STEP_LAST) begin
               next_r.state = r.wait_after ? seq_pkg::ST_WAITI : seq_pkg::ST_VEC0;
            end else if (!r.full && r.step == seq_pkg::STEP_PCH) begin
               next_r.step = seq_pkg::STEP_LAST;                                     // [RULE9]
            end else begin
               next_r.step = r.step + 4'h1;
            end
         end
         // masks take effect as the vector is fetched
         seq_pkg::ST_VEC0: begin
            if (r.set_f) begin
               next_r.regs.condition_code_reg[seq_pkg::CC_F] = 1'b1;
            end
            if (r.set_i) begin
               next_r.regs.condition_code_reg[seq_pkg::CC_I] = 1'b1;
            end
            next_r.mem.addr = r.vec;                                  // [RULE17]
            next_r.mem.re = 1'b1;
            next_r.state = seq_pkg::ST_VEC1;
         end
         seq_pkg::ST_VEC1: begin
            next_r.regs.program_counter[15:8] = mem_rdata;
            next_r.mem.addr = r.vec + 16'h0001;
            next_r.mem.re = 1'b1;
            next_r.state = seq_pkg::ST_VEC2;
         end
         seq_pkg::ST_VEC2: begin
            next_r.regs.program_counter[7:0] = mem_rdata;
            next_r.state = seq_pkg::ST_IDLE;
         end
         // return: codes first, their E bit picks the frame length
         seq_pkg::ST_PULL: begin
            unique case (r.step)
               4'h0: next_r.regs.condition_code_reg = mem_rdata;
               4'h1: next_r.regs.accumulator_high = mem_rdata;
               4'h2: next_r.regs.accumulator_low = mem_rdata;
               4'h3: next_r.regs.direct_page_reg = mem_rdata;
               4'h4: next_r.regs.index_reg_x[15:8] = mem_rdata;
               4'h5: next_r.regs.index_reg_x[7:0] = mem_rdata;
               4'h6: next_r.regs.index_reg_y[15:8] = mem_rdata;
               4'h7: next_r.regs.index_reg_y[7:0] = mem_rdata;
               4'h8: next_r.regs.user_stack_ptr[15:8] = mem_rdata;
               4'h9: next_r.regs.user_stack_ptr[7:0] = mem_rdata;
               4'hA: next_r.regs.program_counter[15:8] = mem_rdata;
               default: next_r.regs.program_counter[7:0] = mem_rdata;
            endcase
            next_r.regs.hardware_stack_ptr = r.regs.hardware_stack_ptr + 16'h0001;
            if (r.step == seq_pkg::STEP_LAST) begin
               next_r.state = seq_pkg::ST_IDLE;
            end else begin
               next_r.mem.addr = next_r.regs.hardware_stack_ptr;
               next_r.mem.re = 1'b1;
               if (r.step == 4'h0 && !mem_rdata[seq_pkg::CC_E]) begin
                  next_r.step = seq_pkg::STEP_PULL_PC;                // [RULE18]
               end else begin
                  next_r.step = r.step + 4'h1;
               end
            end
         end
         // wait for any line; a short or masked one just resumes
         seq_pkg::ST_SYNC: begin
            if (any_line) begin
               next_r.sync_seen = 1'b1;
            end
            if (nmi_go || fast_ok || normal_ok || (any_line && !any_enabled)
                || (r.sync_seen && !any_line)) begin
               next_r.state = seq_pkg::ST_IDLE;                       // [RULE6] [RULE8]
            end
         end
         // frame already stacked, so go straight to the vector
         seq_pkg::ST_WAITI: begin
            next_r.set_f = 1'b1;
            next_r.set_i = 1'b1;
            if (nmi_go) begin
               nmi_take = 1'b1;
               next_r.vec = seq_pkg::VEC_NONMASK;
               next_r.state = seq_pkg::ST_VEC0;
            end else if (fast_ok) begin
               next_r.vec = seq_pkg::VEC_FAST;                        // [RULE10]
               next_r.state = seq_pkg::ST_VEC0;
            end else if (normal_ok) begin
               next_r.vec = seq_pkg::VEC_NORMAL;
               next_r.set_f = 1'b0;
               next_r.state = seq_pkg::ST_VEC0;
            end
         end
         default: next_r.state = seq_pkg::ST_IDLE;
      endcase

      // pins released while synchronising
      next_r.mem.addr_oe = (next_r.state != seq_pkg::ST_SYNC);          // [RULE7]
      next_r.mem.data_oe = next_r.mem.we && (next_r.state != seq_pkg::ST_SYNC);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= SEQ_RESET;                                              // [RULE16]
      end else if (ce) begin
         r <= next_r;
      end
   end

   // zero-wait slave, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = r.hrdata;
   assign mem       = r.mem;
endmodule

/* File: bench/mem_model.sv */
// far-side memory: vector words and stack bytes, read combinationally
`timescale 1ns/1ps
module mem_model (
   input  wire logic              hclk,
   input  wire seq_pkg::mem_out_t mem,
   output logic [7:0]             mem_rdata
);
   logic [7:0] ram [65536];
   logic [7:0] last = 8'h00;
   initial for (int i = 0; i < 65536; i++) ram[i] = 8'(i ^ (i >> 8));
   // a released bus shows the inverse of the last byte, never a stale match
   always @(posedge hclk) if (mem.we) ram[mem.addr] <= mem.wdata; else if (mem.re) last <= ram[mem.addr];
   assign mem_rdata = mem.re ? ram[mem.addr] : ~last;
endmodule

/* File: bench/seq_monitor.sv */
// port assertions of the interrupt sequencer
`timescale 1ns/1ps
module seq_monitor (
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              nonmask_request_n,
   input wire seq_pkg::mem_out_t mem
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // sync wait: no cycles, buses released, ended by an edge
   property p_quiet; !mem.addr_oe |-> !mem.re && !mem.we; endproperty
   a_quiet: assert property (p_quiet) else $error("sync cycle");
   property p_float; !mem.addr_oe |-> !mem.data_oe; endproperty
   a_float: assert property (p_float) else $error("sync drive");
   property p_wake; !mem.addr_oe && $fell(nonmask_request_n) |-> ##[1:6] mem.addr_oe; endproperty
   a_wake: assert property (p_wake) else $error("sync stuck");
   property p_drive; mem.data_oe |-> mem.we; endproperty
   a_drive: assert property (p_drive) else $error("stray drive");
   // stack walks down on push, up on pull
   property p_push; mem.we && $past(mem.we) |-> mem.addr == $past(mem.addr) - 16'h1; endproperty
   a_push: assert property (p_push) else $error("push order");
   property p_pull; mem.re && $past(mem.re) |-> mem.addr == $past(mem.addr) + 16'h1; endproperty
   a_pull: assert property (p_pull) else $error("pull order");
   property p_boot; $rose(hresetn) |-> !mem.we ##1 mem.re && mem.addr == 16'hFFFE
      ##1 mem.addr == 16'hFFFF; endproperty
   a_boot: assert property (p_boot) else $error("boot fetch");
   property p_fast; mem.re && mem.addr == 16'hFFF6 |=> mem.addr == 16'hFFF7; endproperty
   a_fast: assert property (p_fast) else $error("fast vector");
endmodule
bind cpu_interrupt_sequencer seq_monitor seq_monitor_inst (.*);

/* File: bench/tb_top.sv */
// bench: restart, arming, soft traps, nesting and sync
`timescale 1ns/1ps
`define CHK(n,e,s) begin check_count++; if ((s) !== (e)) begin miscompares++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
   logic              hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b1, hwrite = 1'b0, hreadyout, hresp;
   logic              nonmask_request_n = 1'b1, fast_request_input_n = 1'b1, normal_request_n = 1'b1;
   logic [1:0]        htrans = 2'h0;
   logic [2:0]        hsize = 3'h2;
   logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, q, seed = 32'h19;
   logic [7:0]        mem_rdata, a_val;
   wire logic         hready = hreadyout;
   seq_pkg::mem_out_t mem;
   int                miscompares = 0, check_count = 0;
   cpu_interrupt_sequencer cpu_interrupt_sequencer_inst (.*);
   mem_model mem_model_inst (.*);
   initial forever #25 hclk = ~hclk;
   // xorshift stream; vector word as the memory holds it
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] vec(input logic [15:0] a);
      return {16'h0, a[7:0] ^ a[15:8], (a[7:0] + 8'h01) ^ a[15:8]};
   endfunction
   // one single transfer, read data kept in q
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {htrans, hwrite, haddr} <= {2'h2, w, 24'h0, a};
      do @(posedge hclk); while (hready !== 1'b1 && ++n < 9);
      {htrans, hwdata} <= {2'h0, d};
      do @(posedge hclk); while (hready !== 1'b1 && ++n < 9);
      q = hrdata;
      if (n > 8) begin
         miscompares++;
         print_verdict();
      end
   endtask
   // poll until settled, bounded; a miss ends the run
   task automatic exp_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
      int i;
      for (i = 0; i < 60 && (i == 0 || q !== e); i++) bus(1'b0, a, 32'h0);
      `CHK(nm, e, q)
      if (q !== e) print_verdict();
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      exp_reg("pc", 8'h28, vec(16'hFFFE));
      exp_reg("cc", 8'h08, 32'h50);
      // an edge before the first stack load waits
      nonmask_request_n <= 1'b0;
      repeat (20) @(posedge hclk);
      exp_reg("s", 8'h24, 32'h0);
      a_val = 8'(rnd());
      bus(1'b1, 8'h0C, {24'h0, a_val});
      bus(1'b1, 8'h24, 32'h1000);
      exp_reg("pc", 8'h28, vec(16'hFFFC));
      `CHK("a", a_val, mem_model_inst.ram[16'h0FF5])
      nonmask_request_n <= 1'b1;
      bus(1'b1, 8'h00, 32'h4);
      exp_reg("s", 8'h24, 32'h1000);
      $display("arming test done");
      bus(1'b1, 8'h08, 32'h0);
      for (int k = 1; k < 3; k++) begin
         bus(1'b1, 8'h00, 32'(k));
         exp_reg("pc", 8'h28, vec(k == 1 ? 16'hFFF4 : 16'hFFF2));
         exp_reg("cc", 8'h08, 32'h80);
         bus(1'b1, 8'h00, 32'h4);
         exp_reg("s", 8'h24, 32'h1000);
      end
      $display("trap test done");
      // normal entry leaves fast open, so fast nests
      normal_request_n <= 1'b0;
      exp_reg("cc", 8'h08, 32'h90);
      fast_request_input_n <= 1'b0;
      exp_reg("pc", 8'h28, vec(16'hFFF6));
      exp_reg("s", 8'h24, 32'hFF1);
      {normal_request_n, fast_request_input_n} <= 2'h3;
      $display("nesting test done");
      bus(1'b1, 8'h00, 32'h3);
      exp_reg("status", 8'h04, 32'h4040);
      nonmask_request_n <= 1'b0;
      exp_reg("pc", 8'h28, vec(16'hFFFC));
      $display("sync test done");
      // clear-and-wait stacks everything, then fast vectors straight in
      bus(1'b1, 8'h08, 32'h0);
      bus(1'b1, 8'h00, 32'h5);
      exp_reg("status", 8'h04, 32'h4080);
      fast_request_input_n <= 1'b0;
      exp_reg("pc", 8'h28, vec(16'hFFF6));
      exp_reg("s", 8'h24, 32'hFD9);
      $display("wait test done");
      print_verdict();
   end
endmodule
